// file: hw/dcntm_regs.svh
// Behaviour
// - overflow sets timer flag; software clear or interrupt vector clears it. Timer 1 overflow sets no flag while timer 0 is split.
// - run bit per timer, 0 stops, 1 runs subject to gate. Timer 1 ignores its run bit while timer 0 is split.
// - edge type sets external flag on active edge; clear by software or vector.
// - level type flag follows active input level; vector does not clear it.
// - type-select bit per external input, 0 level, 1 edge.
// - gate 0 runs on run bit; gate 1 also needs active external input. Timer 1 ignores its gate while timer 0 is split.
// - count-select 0 uses chosen clock; 1 counts falling edges of count pin. Timer 1 uses its clock while timer 0 is split.
// - timer 0 modes: 13-bit, 16-bit, 8-bit reload, two 8-bit timers.
// - timer 1 modes like timer 0, code 11 makes it inactive.
// - clock-select 0 prescaled, 1 system clock; ignored in counter function.
// - prescale field: sysclk/12, sysclk/4, sysclk/48, external clock/8.
// - external clock is synchronised before dividing by eight.
// - timer 2 high-byte select only in split mode: 1 sysclk, 0 external choice.
// - timer 2 low-byte select clocks whole timer or low byte when split.
// - timer 3 high and low byte selects behave like timer 2 ones.
// - timer 0 low and high count bytes readable, writable, reset zero.
// - timer 1 low count byte readable, writable, reset zero.
// - 13-bit mode uses high byte plus five low bits; flag on wrap.
// - 8-bit reload mode reloads low byte from unchanged high byte.
// - timer 0 split high byte runs on timer 1 run bit, sets its flag.
`ifndef DCNTM_REGS_SVH
`define DCNTM_REGS_SVH

// ==========================================
// register addresses
`define DCNTM_ADDR_TCS   8'h88
`define DCNTM_ADDR_TMS   8'h89
`define DCNTM_ADDR_TL0   8'h8A
`define DCNTM_ADDR_TL1   8'h8B
`define DCNTM_ADDR_TH0   8'h8C
`define DCNTM_ADDR_TH1   8'h8D
`define DCNTM_ADDR_CKS   8'h8E
`define DCNTM_RESET_VAL  8'h00
`define DCNTM_READ_ZERO  8'h00

// ==========================================
// control/status bits
`define DCNTM_TF1        7
`define DCNTM_TR1        6
`define DCNTM_TF0        5
`define DCNTM_TR0        4
`define DCNTM_IE1        3
`define DCNTM_IT1        2
`define DCNTM_IE0        1
`define DCNTM_IT0        0

// ==========================================
// mode select fields
`define DCNTM_TIMER1_GATE_ENABLE      7
`define DCNTM_CT1        6
`define DCNTM_T1M_HI     5
`define DCNTM_T1M_LO     4
`define DCNTM_TIMER0_GATE_ENABLE      3
`define DCNTM_CT0        2
`define DCNTM_T0M_HI     1
`define DCNTM_T0M_LO     0

// ==========================================
// clock select fields
`define DCNTM_TIMER3_HIBYTE_SYSCLK_SEL       7
`define DCNTM_TIMER3_LOBYTE_SYSCLK_SEL       6
`define DCNTM_TIMER2_HIBYTE_SYSCLK_SEL       5
`define DCNTM_TIMER2_LOBYTE_SYSCLK_SEL       4
`define DCNTM_T1SYS      3
`define DCNTM_T0SYS      2
`define DCNTM_SCA_HI     1
`define DCNTM_SCA_LO     0

// ==========================================
// prescaler codes and divider counts
`define DCNTM_PSC_DIV12  2'h0
`define DCNTM_PSC_DIV4   2'h1
`define DCNTM_PSC_DIV48  2'h2
`define DCNTM_PSC_EXT8   2'h3
`define DCNTM_DIV12_LAST 4'hB
`define DCNTM_DIV4_LAST  2'h3
`define DCNTM_DIV48_LAST 2'h3
`define DCNTM_EXT8_LAST  3'h7
`define DCNTM_T13_LO_MSB 4
`define DCNTM_BYTE_MSB   7

`endif

// file: hw/dcntm_pkg.sv
package dcntm_pkg;
  typedef logic [7:0] dcntm_byte_t;
  // operating mode field, enumerated in field-code order
  typedef enum logic [1:0] {
    DCNTM_MODE_13BIT,
    DCNTM_MODE_16BIT,
    DCNTM_MODE_RELOAD8,
    DCNTM_MODE_SPLIT8
  } dcntm_mode_e;
endpackage

// file: hw/dcntm_tick_if.sv
`timescale 1ns/1ps
// ==========================================
// prescaler to timer core ticks
interface dcntm_tick_if;
  logic [1:0] prescale_sel;
  logic       presc_tick;
  logic       div12_tick;
  logic       ext8_tick;
  modport src (input prescale_sel, output presc_tick, output div12_tick, output ext8_tick);
  modport dst (output prescale_sel, input presc_tick, input div12_tick, input ext8_tick);
endinterface

// file: hw/dcntm_pin.sv
`timescale 1ns/1ps
`include "dcntm_regs.svh"
// ==========================================
// pin sampler with active level and active-edge pulse
module dcntm_pin (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pin,
  input  wire logic active_high,
  output logic      active,
  output logic      active_edge
);
  logic sample;
  logic sample_prev;
  logic next_sample;
  logic next_sample_prev;

  // next sample values
  always_comb begin
    next_sample      = pin;
    next_sample_prev = sample;
  end

  // sample registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sample      <= 1'b0;
      sample_prev <= 1'b0;
    end else begin
      sample      <= next_sample;
      sample_prev <= next_sample_prev;
    end
  end

  // transition into the active level
  assign active      = (sample == active_high);
  assign active_edge = active && (sample_prev != active_high);
endmodule

// file: hw/dcntm_prescale.sv
`timescale 1ns/1ps
`include "dcntm_regs.svh"
// ==========================================
// shared prescaler and external clock divider
module dcntm_prescale (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic ext_osc_clk,
  dcntm_tick_if.src tick
);
  logic [3:0] cnt12;
  logic [1:0] cnt48;
  logic [2:0] cnt8;
  logic       ext_s1;
  logic       ext_s2;
  logic       ext_s3;
  logic       presc;
  logic       d12;
  logic       e8;
  logic [3:0] next_cnt12;
  logic [1:0] next_cnt48;
  logic [2:0] next_cnt8;
  logic       next_presc;
  logic       next_d12;
  logic       next_e8;
  logic       wrap12;
  logic       ext_rise;

  // divider next state
  always_comb begin
    wrap12     = (cnt12 == `DCNTM_DIV12_LAST);
    ext_rise   = ext_s2 && !ext_s3;
    next_cnt12 = wrap12 ? 4'h0 : cnt12 + 4'h1;
    next_cnt48 = wrap12 ? cnt48 + 2'h1 : cnt48;
    next_cnt8  = ext_rise ? cnt8 + 3'h1 : cnt8;
    next_d12   = wrap12;
    next_e8    = ext_rise && (cnt8 == `DCNTM_EXT8_LAST);
    case (tick.prescale_sel)
      `DCNTM_PSC_DIV12: next_presc = wrap12;
      `DCNTM_PSC_DIV4:  next_presc = (cnt12[1:0] == `DCNTM_DIV4_LAST);
      `DCNTM_PSC_DIV48: next_presc = wrap12 && (cnt48 == `DCNTM_DIV48_LAST);
      `DCNTM_PSC_EXT8:  next_presc = next_e8;
      default:          next_presc = 1'b0;
    endcase
  end

  // divider and synchroniser registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt12  <= 4'h0;
      cnt48  <= 2'h0;
      cnt8   <= 3'h0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      presc  <= 1'b0;
      d12    <= 1'b0;
      e8     <= 1'b0;
    end else begin
      cnt12  <= next_cnt12;
      cnt48  <= next_cnt48;
      cnt8   <= next_cnt8;
      ext_s1 <= ext_osc_clk;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      presc  <= next_presc;
      d12    <= next_d12;
      e8     <= next_e8;
    end
  end

  assign tick.presc_tick = presc;
  assign tick.div12_tick = d12;
  assign tick.ext8_tick  = e8;
endmodule

// file: hw/dcntm_top.sv
`timescale 1ns/1ps
`include "dcntm_regs.svh"
// ==========================================
// dual counter/timer control with register access
module dcntm_top (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic [7:0]         sfr_addr,
  input  wire logic               sfr_wr,
  input  wire logic               sfr_rd,
  input  wire dcntm_pkg::dcntm_byte_t sfr_wdata,
  output dcntm_pkg::dcntm_byte_t  sfr_rdata,
  input  wire logic               ext_irq_input_zero,
  input  wire logic               ext_irq_input_one,
  input  wire logic               ext_irq0_polarity,
  input  wire logic               ext_irq1_polarity,
  input  wire logic               count_input_zero,
  input  wire logic               count_input_one,
  input  wire logic               ext_osc_clk,
  input  wire logic               ack_timer0,
  input  wire logic               ack_timer1,
  input  wire logic               ack_ext_irq0,
  input  wire logic               ack_ext_irq1,
  input  wire logic               timer2_split,
  input  wire logic               timer2_ext_clock_select,
  input  wire logic               timer3_split,
  input  wire logic               timer3_ext_clock_select,
  output logic                    timer0_overflow_flag,
  output logic                    timer1_overflow_flag,
  output logic                    ext_irq0_flag,
  output logic                    ext_irq1_flag,
  output logic                    timer1_overflow_tick,
  output logic                    timer2_lo_tick,
  output logic                    timer2_hi_tick,
  output logic                    timer3_lo_tick,
  output logic                    timer3_hi_tick
);
  import dcntm_pkg::*;

  dcntm_byte_t timer_control_status;
  dcntm_byte_t timer_mode_select;
  dcntm_byte_t timer0_low_byte;
  dcntm_byte_t timer1_low_byte;
  dcntm_byte_t timer0_high_byte;
  dcntm_byte_t timer1_high_byte;
  dcntm_byte_t timer_clock_select;
  dcntm_byte_t rdata;
  logic        t1_ovf_tick;
  logic        t2_lo;
  logic        t2_hi;
  logic        t3_lo;
  logic        t3_hi;

  dcntm_byte_t next_timer_control_status;
  dcntm_byte_t next_timer_mode_select;
  dcntm_byte_t next_timer0_low_byte;
  dcntm_byte_t next_timer1_low_byte;
  dcntm_byte_t next_timer0_high_byte;
  dcntm_byte_t next_timer1_high_byte;
  dcntm_byte_t next_timer_clock_select;
  dcntm_byte_t next_rdata;
  logic        next_t1_ovf_tick;
  logic        next_t2_lo;
  logic        next_t2_hi;
  logic        next_t3_lo;
  logic        next_t3_hi;

  logic        ext_irq_input_zero_active;
  logic        ext_irq_input_zero_edge;
  logic        ext_irq_input_one_active;
  logic        ext_irq_input_one_edge;
  logic        cnt0_fall;
  logic        cnt1_fall;
  logic        timer0_step;
  logic        timer1_step;
  logic        th0_step;
  logic        timer0_ovf;
  logic        timer1_ovf;
  logic        th0_ovf;
  logic        t0_split;
  logic        t0_clk;
  logic        t1_clk;
  logic        t2_choice;
  logic        t3_choice;
  dcntm_mode_e t0_mode;
  dcntm_mode_e t1_mode;
  logic [16:0] t0_res;
  logic [16:0] t1_res;
  logic [8:0]  th0_res;

  dcntm_tick_if tick_bus ();

  // ==========================================
  // pin samplers and prescaler
  dcntm_pin u_ext_irq_input_zero (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .pin         (ext_irq_input_zero),
    .active_high (ext_irq0_polarity),
    .active      (ext_irq_input_zero_active),
    .active_edge (ext_irq_input_zero_edge)
  );

  dcntm_pin u_ext_irq_input_one (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .pin         (ext_irq_input_one),
    .active_high (ext_irq1_polarity),
    .active      (ext_irq_input_one_active),
    .active_edge (ext_irq_input_one_edge)
  );

  // count pins: active low, so the edge pulse is a high-to-low transition
  dcntm_pin u_cnt0 (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .pin         (count_input_zero),
    .active_high (1'b0),
    .active      (),
    .active_edge (cnt0_fall)
  );

  dcntm_pin u_cnt1 (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .pin         (count_input_one),
    .active_high (1'b0),
    .active      (),
    .active_edge (cnt1_fall)
  );

  dcntm_prescale u_presc (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .ext_osc_clk (ext_osc_clk),
    .tick        (tick_bus)
  );

  assign tick_bus.prescale_sel = timer_clock_select[`DCNTM_SCA_HI:`DCNTM_SCA_LO];

  // ==========================================
  // helpers
  // timer clock: system clock or prescaled tick
  function automatic logic timer_clock(input logic sys_sel, input logic presc);
    timer_clock = sys_sel | presc;
  endfunction

  // one count step; returns {overflow, high, low}
  function automatic logic [16:0] tmr_step(input dcntm_mode_e m, input dcntm_byte_t lo,
                                           input dcntm_byte_t hi, input logic en);
    logic [12:0] c13;
    logic [15:0] c16;
    logic [8:0]  c8;
    c13 = {hi, lo[`DCNTM_T13_LO_MSB:0]} + 13'h0001;
    c16 = {hi, lo} + 16'h0001;
    c8  = {1'b0, lo} + 9'h001;
    tmr_step = {1'b0, hi, lo};
    if (en) begin
      case (m)
        DCNTM_MODE_13BIT:
          tmr_step = {&{hi, lo[`DCNTM_T13_LO_MSB:0]}, c13[12:`DCNTM_T13_LO_MSB+1],
                      lo[`DCNTM_BYTE_MSB:`DCNTM_T13_LO_MSB+1], c13[`DCNTM_T13_LO_MSB:0]};
        DCNTM_MODE_16BIT:
          tmr_step = {&{hi, lo}, c16};
        DCNTM_MODE_RELOAD8:
          tmr_step = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
        DCNTM_MODE_SPLIT8:
          tmr_step = {c8[8], hi, c8[7:0]};
        default:
          tmr_step = {1'b0, hi, lo};
      endcase
    end
  endfunction

  // ==========================================
  // counting, flags, register writes and reads
  always_comb begin
    t0_mode  = dcntm_mode_e'(timer_mode_select[`DCNTM_T0M_HI:`DCNTM_T0M_LO]);
    t1_mode  = dcntm_mode_e'(timer_mode_select[`DCNTM_T1M_HI:`DCNTM_T1M_LO]);
    t0_split = (t0_mode == DCNTM_MODE_SPLIT8);
    t0_clk   = timer_clock(timer_clock_select[`DCNTM_T0SYS], tick_bus.presc_tick);
    t1_clk   = timer_clock(timer_clock_select[`DCNTM_T1SYS], tick_bus.presc_tick);
    // timer 0: gate, run and source
    timer0_step = timer_control_status[`DCNTM_TR0]
                  && (!timer_mode_select[`DCNTM_TIMER0_GATE_ENABLE] || ext_irq_input_zero_active)
                  && (timer_mode_select[`DCNTM_CT0] ? cnt0_fall : t0_clk);
    // timer 1: with timer 0 split it runs on its mode and timer clock only
    if (t0_split) begin
      timer1_step = (t1_mode != DCNTM_MODE_SPLIT8) && t1_clk;
    end else begin
      timer1_step = timer_control_status[`DCNTM_TR1]
                    && (!timer_mode_select[`DCNTM_TIMER1_GATE_ENABLE] || ext_irq_input_one_active)
                    && (t1_mode != DCNTM_MODE_SPLIT8)
                    && (timer_mode_select[`DCNTM_CT1] ? cnt1_fall : t1_clk);
    end
    th0_step   = t0_split && timer_control_status[`DCNTM_TR1] && t0_clk;
    t0_res     = tmr_step(t0_mode, timer0_low_byte, timer0_high_byte, timer0_step);
    t1_res     = tmr_step(t1_mode, timer1_low_byte, timer1_high_byte, timer1_step);
    th0_res    = {1'b0, timer0_high_byte} + 9'h001;
    timer0_ovf = t0_res[16];
    timer1_ovf = t1_res[16];
    th0_ovf    = th0_step && th0_res[8];

    // counts: a software write overrides the step of the same cycle
    next_timer0_low_byte  = t0_res[7:0];
    next_timer0_high_byte = th0_step ? th0_res[7:0] : t0_res[15:8];
    next_timer1_low_byte  = t1_res[7:0];
    next_timer1_high_byte = t1_res[15:8];
    next_timer_control_status = timer_control_status;
    next_timer_mode_select    = timer_mode_select;
    next_timer_clock_select   = timer_clock_select;
    if (sfr_wr) begin
      case (sfr_addr)
        `DCNTM_ADDR_TCS: next_timer_control_status = sfr_wdata;
        `DCNTM_ADDR_TMS: next_timer_mode_select    = sfr_wdata;
        `DCNTM_ADDR_TL0: next_timer0_low_byte      = sfr_wdata;
        `DCNTM_ADDR_TL1: next_timer1_low_byte      = sfr_wdata;
        `DCNTM_ADDR_TH0: next_timer0_high_byte     = sfr_wdata;
        `DCNTM_ADDR_TH1: next_timer1_high_byte     = sfr_wdata;
        `DCNTM_ADDR_CKS: next_timer_clock_select   = sfr_wdata;
        default:         next_timer_control_status = timer_control_status;
      endcase
    end

    // overflow flags: vector ack clears, hardware set wins
    next_timer_control_status[`DCNTM_TF0] =
      (next_timer_control_status[`DCNTM_TF0] && !ack_timer0) || timer0_ovf;
    next_timer_control_status[`DCNTM_TF1] =
      (next_timer_control_status[`DCNTM_TF1] && !ack_timer1)
      || th0_ovf || (timer1_ovf && !t0_split);

    // external interrupt flags: edge latched or level followed
    if (timer_control_status[`DCNTM_IT0]) begin
      next_timer_control_status[`DCNTM_IE0] =
        (next_timer_control_status[`DCNTM_IE0] && !ack_ext_irq0) || ext_irq_input_zero_edge;
    end else begin
      next_timer_control_status[`DCNTM_IE0] = ext_irq_input_zero_active;
    end
    if (timer_control_status[`DCNTM_IT1]) begin
      next_timer_control_status[`DCNTM_IE1] =
        (next_timer_control_status[`DCNTM_IE1] && !ack_ext_irq1) || ext_irq_input_one_edge;
    end else begin
      next_timer_control_status[`DCNTM_IE1] = ext_irq_input_one_active;
    end

    // timer 1 overflow pulse, also while timer 0 is split
    next_t1_ovf_tick = timer1_ovf;

    // clock enables for timers 2 and 3
    t2_choice  = timer2_ext_clock_select ? tick_bus.ext8_tick : tick_bus.div12_tick;
    t3_choice  = timer3_ext_clock_select ? tick_bus.ext8_tick : tick_bus.div12_tick;
    next_t2_lo = timer_clock_select[`DCNTM_TIMER2_LOBYTE_SYSCLK_SEL] | t2_choice;
    next_t2_hi = timer2_split ? (timer_clock_select[`DCNTM_TIMER2_HIBYTE_SYSCLK_SEL] | t2_choice)
                              : next_t2_lo;
    next_t3_lo = timer_clock_select[`DCNTM_TIMER3_LOBYTE_SYSCLK_SEL] | t3_choice;
    next_t3_hi = timer3_split ? (timer_clock_select[`DCNTM_TIMER3_HIBYTE_SYSCLK_SEL] | t3_choice)
                              : next_t3_lo;

    // read data, unmapped addresses read zero
    next_rdata = rdata;
    if (sfr_rd) begin
      case (sfr_addr)
        `DCNTM_ADDR_TCS: next_rdata = timer_control_status;
        `DCNTM_ADDR_TMS: next_rdata = timer_mode_select;
        `DCNTM_ADDR_TL0: next_rdata = timer0_low_byte;
        `DCNTM_ADDR_TL1: next_rdata = timer1_low_byte;
        `DCNTM_ADDR_TH0: next_rdata = timer0_high_byte;
        `DCNTM_ADDR_TH1: next_rdata = timer1_high_byte;
        `DCNTM_ADDR_CKS: next_rdata = timer_clock_select;
        default:         next_rdata = `DCNTM_READ_ZERO;
      endcase
    end
  end

  // state registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      timer_control_status <= `DCNTM_RESET_VAL;
      timer_mode_select    <= `DCNTM_RESET_VAL;
      timer0_low_byte      <= `DCNTM_RESET_VAL;
      timer1_low_byte      <= `DCNTM_RESET_VAL;
      timer0_high_byte     <= `DCNTM_RESET_VAL;
      timer1_high_byte     <= `DCNTM_RESET_VAL;
      timer_clock_select   <= `DCNTM_RESET_VAL;
      rdata                <= `DCNTM_READ_ZERO;
      t1_ovf_tick          <= 1'b0;
      t2_lo                <= 1'b0;
      t2_hi                <= 1'b0;
      t3_lo                <= 1'b0;
      t3_hi                <= 1'b0;
    end else begin
      timer_control_status <= next_timer_control_status;
      timer_mode_select    <= next_timer_mode_select;
      timer0_low_byte      <= next_timer0_low_byte;
      timer1_low_byte      <= next_timer1_low_byte;
      timer0_high_byte     <= next_timer0_high_byte;
      timer1_high_byte     <= next_timer1_high_byte;
      timer_clock_select   <= next_timer_clock_select;
      rdata                <= next_rdata;
      t1_ovf_tick          <= next_t1_ovf_tick;
      t2_lo                <= next_t2_lo;
      t2_hi                <= next_t2_hi;
      t3_lo                <= next_t3_lo;
      t3_hi                <= next_t3_hi;
    end
  end

  // outputs straight from registers
  assign sfr_rdata            = rdata;
  assign timer0_overflow_flag = timer_control_status[`DCNTM_TF0];
  assign timer1_overflow_flag = timer_control_status[`DCNTM_TF1];
  assign ext_irq0_flag        = timer_control_status[`DCNTM_IE0];
  assign ext_irq1_flag        = timer_control_status[`DCNTM_IE1];
  assign timer1_overflow_tick = t1_ovf_tick;
  assign timer2_lo_tick       = t2_lo;
  assign timer2_hi_tick       = t2_hi;
  assign timer3_lo_tick       = t3_lo;
  assign timer3_hi_tick       = t3_hi;
endmodule

// file: verification/dcntm_top_assertions.sv
`timescale 1ns/1ps
// ==========================================
// port checks of the counter/timer control
module dcntm_top_checker (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       ext_irq_input_zero,
  input wire logic       ext_irq0_polarity,
  input wire logic       ack_timer0,
  input wire logic       ack_timer1,
  input wire logic       timer2_split,
  input wire logic       timer0_overflow_flag,
  input wire logic       timer1_overflow_flag,
  input wire logic       ext_irq0_flag,
  input wire logic       timer2_lo_tick,
  input wire logic       timer2_hi_tick
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // read strobes of interest
  sequence s_rd_unmapped;
    sfr_rd && sfr_addr == 8'h8F;
  endsequence
  sequence s_rd_status;
    sfr_rd && !sfr_wr && sfr_addr == 8'h88;
  endsequence
  // read path
  chk_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved");
  chk_rdata_reset: assert property (!$past(rst_n) |-> sfr_rdata == 8'h00)
    else $error("read data not cleared");
  chk_unmapped_zero: assert property (s_rd_unmapped |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_status_flags: assert property (s_rd_status |=> sfr_rdata[7] == $past(timer1_overflow_flag)
    && sfr_rdata[5] == $past(timer0_overflow_flag) && sfr_rdata[1] == $past(ext_irq0_flag))
    else $error("status read mismatch");
  // flags drop only by ack or write, rise only by cause
  chk_tf0_clear: assert property ($fell(timer0_overflow_flag) |->
    $past(ack_timer0) || $past(sfr_wr) || !$past(rst_n)) else $error("flag 0 dropped alone");
  chk_tf1_clear: assert property ($fell(timer1_overflow_flag) |->
    $past(ack_timer1) || $past(sfr_wr) || !$past(rst_n)) else $error("flag 1 dropped alone");
  chk_ie0_rise: assert property ($rose(ext_irq0_flag) |-> $past(sfr_wr) ||
    $past(ext_irq_input_zero) == ext_irq0_polarity || $past(ext_irq_input_zero, 2) == ext_irq0_polarity
    || $past(ext_irq_input_zero, 3) == ext_irq0_polarity) else $error("ext flag rose alone");
  chk_t2_joined: assert property (!timer2_split && !$past(timer2_split) |->
    timer2_hi_tick == timer2_lo_tick) else $error("timer 2 bytes differ");
endmodule

bind dcntm_top dcntm_top_checker u_chk (.*);

// file: verification/dcntm_cpu_model.sv
`timescale 1ns/1ps
// ==========================================
// cpu side: register strobes and vector acks
module dcntm_cpu_model (
  input  wire logic       sys_clk,
  output logic [7:0]      sfr_addr,
  output logic            sfr_wr,
  output logic            sfr_rd,
  output logic [7:0]      sfr_wdata,
  input  wire logic [7:0] sfr_rdata,
  output logic [3:0]      ack
);
  // idle bus at time zero
  initial begin
    {sfr_addr, sfr_wr, sfr_rd, sfr_wdata, ack} = '0;
  end
  // strobe held over its edge, data spoiled after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #2 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge sys_clk);
    #2 sfr_wr = 1'b0;
    sfr_wdata = ~d;
  endtask
  // registered read data taken after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #2 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge sys_clk);
    #1 d = sfr_rdata;
    #1 sfr_rd = 1'b0;
    sfr_addr = ~a;
  endtask
  // one-cycle vector acknowledge per source
  task automatic vec(input int n);
    @(posedge sys_clk);
    #2 ack[n] = 1'b1;
    @(posedge sys_clk);
    #2 ack[n] = 1'b0;
  endtask
endmodule

// file: verification/tb_dcntm_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
// ==========================================
// bench top
module tb_dcntm_top;
  logic       sys_clk, rst_n, sfr_wr, sfr_rd, ext_osc_clk, count_input_zero, count_input_one;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
  logic       ext_irq_input_zero, ext_irq_input_one, ext_irq0_polarity, ext_irq1_polarity;
  logic       ack_timer0, ack_timer1, ack_ext_irq0, ack_ext_irq1, timer2_split, timer3_split;
  logic       timer2_ext_clock_select, timer3_ext_clock_select, timer1_overflow_tick;
  logic       timer0_overflow_flag, timer1_overflow_flag, ext_irq0_flag, ext_irq1_flag;
  logic       timer2_lo_tick, timer2_hi_tick, timer3_lo_tick, timer3_hi_tick;
  logic [3:0] ack;
  int         miscompares, num_checks, dv[4] = '{12, 4, 48, 32};
  assign {ack_ext_irq1, ack_ext_irq0, ack_timer1, ack_timer0} = ack;
  dcntm_top DUT (.*);
  dcntm_cpu_model cpu (.*);
  // clocks: system and free running oscillator
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    ext_osc_clk = 1'b0;
    forever #50 ext_osc_clk = ~ext_osc_clk;
  end
  // ==========================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    cpu.rd(a, d);
    `CHK(d, e)
  endtask
  task automatic setup(input logic [7:0] md, ck, tl, th, tc);
    cpu.wr(8'h88, 8'h00);
    cpu.wr(8'h89, md);
    cpu.wr(8'h8E, ck);
    cpu.wr(8'h8A, tl);
    cpu.wr(8'h8C, th);
    cpu.wr(8'h88, tc);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      cyc(3);
      count_input_zero = 1'b0;
      cyc(3);
      count_input_zero = 1'b1;
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard
  initial begin
    #250000;
    miscompares++;
    tally_and_finish();
  end
  // ==========================================
  // tests
  initial begin
    {rst_n, ext_irq_input_zero, ext_irq_input_one, timer2_split, timer3_split} = '0;
    {timer2_ext_clock_select, timer3_ext_clock_select} = '0;
    {ext_irq0_polarity, ext_irq1_polarity, count_input_zero, count_input_one} = '1;
    cyc(4);
    rst_n = 1'b1;
    for (int a = 8'h88; a <= 8'h8F; a++) rchk(a[7:0], 8'h00);
    for (int a = 8'h89; a <= 8'h8E; a++) begin
      cpu.wr(a[7:0], 8'h5A);
      rchk(a[7:0], 8'h5A);
      cpu.wr(a[7:0], 8'h00);
    end
    setup(8'h01, 8'h04, 8'hFD, 8'hFF, 8'h10);
    cyc(6);
    `CHK(timer0_overflow_flag, 1'b1)
    cpu.vec(0);
    `CHK(timer0_overflow_flag, 1'b0)
    setup(8'h01, 8'h04, 8'h10, 8'h00, 8'h00);
    cyc(10);
    rchk(8'h8A, 8'h10);
    setup(8'h02, 8'h04, 8'hFE, 8'h80, 8'h10);
    cyc(300);
    `CHK(timer0_overflow_flag, 1'b1)
    cpu.wr(8'h88, 8'h00);
    rchk(8'h8C, 8'h80);
    cpu.rd(8'h8A, d);
    `CHK(d[7], 1'b1)
    setup(8'h00, 8'h04, 8'h1E, 8'hFF, 8'h10);
    cyc(6);
    `CHK(timer0_overflow_flag, 1'b1)
    cpu.wr(8'h88, 8'h00);
    rchk(8'h8C, 8'h00);
    setup(8'h03, 8'h04, 8'h00, 8'hFF, 8'h40);
    cyc(6);
    `CHK({timer1_overflow_flag, timer0_overflow_flag}, 2'b10)
    rchk(8'h8A, 8'h00);
    cpu.vec(1);
    `CHK(timer1_overflow_flag, 1'b0)
    setup(8'h30, 8'h08, 8'h00, 8'h00, 8'h40);
    cpu.wr(8'h8B, 8'h00);
    cyc(10);
    rchk(8'h8B, 8'h00);
    setup(8'h10, 8'h08, 8'h00, 8'h00, 8'h40);
    cyc(10);
    cpu.rd(8'h8B, d);
    `CHK(d > 8'h05, 1'b1)
    cpu.wr(8'h8D, 8'hFF);
    cpu.wr(8'h8B, 8'hFF);
    cyc(1);
    `CHK({timer1_overflow_tick, timer1_overflow_flag}, 2'b11)
    setup(8'h0D, 8'h04, 8'h00, 8'h00, 8'h10);
    pulses(3);
    ext_irq_input_zero = 1'b1;
    cyc(3);
    pulses(4);
    rchk(8'h8A, 8'h04);
    cpu.wr(8'h88, 8'h00);
    ext_irq_input_zero = 1'b0;
    {ext_irq0_polarity, ext_irq1_polarity} = 2'b00;
    cyc(4);
    `CHK({ext_irq1_flag, ext_irq0_flag}, 2'b11)
    cpu.vec(2);
    `CHK(ext_irq0_flag, 1'b1)
    ext_irq_input_zero = 1'b1;
    cyc(4);
    `CHK(ext_irq0_flag, 1'b0)
    ext_irq_input_zero = 1'b0;
    {ext_irq0_polarity, ext_irq1_polarity} = 2'b11;
    cpu.wr(8'h88, 8'h01);
    cyc(4);
    `CHK(ext_irq0_flag, 1'b0)
    ext_irq_input_zero = 1'b1;
    cyc(4);
    `CHK(ext_irq0_flag, 1'b1)
    cpu.vec(2);
    `CHK(ext_irq0_flag, 1'b0)
    for (int i = 0; i < 4; i++) begin
      setup(8'h01, i[7:0], 8'h00, 8'h00, 8'h10);
      cyc(480);
      cpu.wr(8'h88, 8'h00);
      cpu.rd(8'h8A, d);
      `CHK(d >= 480 / dv[i] - 1 && d <= 480 / dv[i] + 2, 1'b1)
    end
    {timer2_split, timer3_split} = 2'b11;
    cpu.wr(8'h8E, 8'hF0);
    cyc(3);
    `CHK({timer2_lo_tick, timer2_hi_tick, timer3_lo_tick, timer3_hi_tick}, 4'hF)
    {timer2_split, timer3_split} = 2'b00;
    cpu.wr(8'h8E, 8'h00);
    cyc(30);
    tally_and_finish();
  end
endmodule
